// File: dowl_pkg.sv
// Purpose: shared constants and types for the termination and leveling link
// Assumes: clk_i is the memory clock CK at 100 MHz, all counts in real CK edges
// Notes: times are kept in ps and turned into cycle counts here
package dowl_pkg;
  localparam int CK_PS = 10000;
  localparam int LAT_W = 5;
  localparam int NOM_TO_WR_SUB = 2;
  localparam int TERM_OFF_SUB = 2;
  localparam int WR_TO_NOM_CHOP_CK = 4;
  localparam int WR_TO_NOM_FULL_CK = 6;
  localparam int DLL_OFF_RD_SUB = 1;
  localparam int TERM_WIN_MIN_PCT = 30;
  localparam int TERM_WIN_MAX_PCT = 70;
  localparam int LVL_FIRST_WAIT_CK = 40;
  localparam int LVL_FB_DELAY_PS = 7500;
  localparam int LVL_FB_SKEW_PS = 2000;
  localparam int TERM_HOLD_FULL_CK = 6;
  localparam int TERM_HOLD_CHOP_CK = 4;
  localparam int RELOCK_MIN_CK = 10;
  localparam int RELOCK_MIN_PS = 24000;

  function automatic int ceil_ck(input int ps);
    ceil_ck = (ps + CK_PS - 1) / CK_PS;
    if (ceil_ck < 1) ceil_ck = 1;
  endfunction

  function automatic int floor_ck(input int ps);
    floor_ck = ps / CK_PS;
    if (floor_ck < 1) floor_ck = 1;
  endfunction

  // device answers at its longest allowed point, rounded down
  localparam int LVL_FB_DEV_CK = floor_ck(LVL_FB_DELAY_PS);
  // controller must cover the worst case, so it rounds up
  localparam int LVL_FB_WAIT_CK = ceil_ck(LVL_FB_DELAY_PS) + ceil_ck(LVL_FB_SKEW_PS);
  localparam int RELOCK_CK = (ceil_ck(RELOCK_MIN_PS) > RELOCK_MIN_CK) ?
                             ceil_ck(RELOCK_MIN_PS) : RELOCK_MIN_CK;

  localparam logic [LAT_W-1:0] CWL_RST = 5'h05;
  localparam logic [LAT_W-1:0] AL_RST = 5'h00;
  localparam logic [LAT_W-1:0] CL_RST = 5'h06;

  typedef enum logic [2:0] {CMD_NOP, CMD_WRITE, CMD_READ, CMD_MRS, CMD_WL_ENTER, CMD_WL_EXIT} dowl_cmd_type;
  typedef enum logic [1:0] {TERM_OFF, TERM_NOM, TERM_WR} dowl_term_type;
endpackage

// File: dowl_link_if.sv
// Purpose: link between memory controller end and memory device end
// Assumes: both ends run on the one clock, clk_i = CK
// Notes: dq feedback is a two-way pin modelled by value plus enable
`timescale 1ns/1ps
interface dowl_link_if #(
  parameter int DQ_W = 8,
  parameter int PH_W = 4
);
  dowl_pkg::dowl_cmd_type cmd;
  logic bc4;
  logic odt;
  logic dqs_rise;
  logic [PH_W-1:0] dqs_phase;
  logic [dowl_pkg::LAT_W-1:0] cwl;
  logic [dowl_pkg::LAT_W-1:0] al;
  logic [dowl_pkg::LAT_W-1:0] cl;
  logic dll_off;
  logic dyn_en;
  logic [DQ_W-1:0] dq_fb;
  logic dq_oe;

  modport dev (input cmd, bc4, odt, dqs_rise, dqs_phase, cwl, al, cl, dll_off, dyn_en,
               output dq_fb, dq_oe);
  modport host (output cmd, bc4, odt, dqs_rise, dqs_phase, cwl, al, cl, dll_off, dyn_en,
                input dq_fb, dq_oe);
endinterface // dowl_link_if

// File: dowl_dly.sv
// Purpose: shift line with a run-time tap for latency counting
// Assumes: tap_i stays stable while traffic is in flight
// Notes: out_o shows the input tap_i edges later, a follower flop adds one
`timescale 1ns/1ps
module dowl_dly #(
  parameter int W = 1,
  parameter int DEPTH = 32
) (
  input wire logic clk_i, // memory clock
  input wire logic sys_rst_i, // async reset, high
  input wire logic [W-1:0] in_i, // value taken each edge
  input wire logic [$clog2(DEPTH)-1:0] tap_i, // latency in edges
  output logic [W-1:0] out_o // delayed value, combinational
);
  logic [W-1:0] stage_q [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          stage_q[g] <= '0;
        end else begin
          stage_q[g] <= (g == 0) ? in_i : stage_q[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  // counted in real edges, never in elapsed time
  always_comb begin
    if (tap_i == '0) begin
      out_o = in_i;
    end else begin
      out_o = stage_q[tap_i - 1'b1];
    end
  end
endmodule // dowl_dly

// File: dowl_dev.sv
// Purpose: memory device end: dynamic termination timing and leveling feedback
// Assumes: commands, termination input and strobe events are synchronous to clk_i
// Notes: termination output is a state code, the analog switch follows it
`timescale 1ns/1ps
module dowl_dev #(
  parameter int DQ_W = 8,
  parameter int PH_W = 4,
  parameter int DEPTH = 32
) (
  input wire logic clk_i, // memory clock CK
  input wire logic sys_rst_i, // async reset, high
  dowl_link_if.dev link, // link from the controller
  output dowl_pkg::dowl_term_type term_o, // termination in force
  output logic rd_ref_o, // read strobe reference clock pulse
  output logic wl_mode_o, // write leveling mode active
  output logic dll_off_o // DLL-disabled operation selected
);
  localparam int TAP_W = $clog2(DEPTH);

  logic [dowl_pkg::LAT_W-1:0] cwl_q;
  logic [dowl_pkg::LAT_W-1:0] al_q;
  logic [dowl_pkg::LAT_W-1:0] cl_q;
  logic dll_off_q;
  logic dyn_en_q;
  logic wl_mode_q;

  logic [dowl_pkg::LAT_W:0] wl_sum;
  logic [dowl_pkg::LAT_W:0] rl_sum;
  logic [TAP_W-1:0] term_tap;
  logic [TAP_W-1:0] rd_tap;

  logic odt_late;
  logic [1:0] wr_in;
  logic [1:0] wr_late;
  logic rd_in;
  logic rd_late;

  logic win_q;
  logic win_d;
  logic [TAP_W:0] win_cnt_q;
  dowl_pkg::dowl_term_type term_q;
  dowl_pkg::dowl_term_type term_d;
  logic rd_ref_q;

  logic fb_q;
  logic fb_oe_q;
  logic ck_level;

  // mode state, loaded by the mode register command
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cwl_q <= dowl_pkg::CWL_RST;
      al_q <= dowl_pkg::AL_RST;
      cl_q <= dowl_pkg::CL_RST;
      dll_off_q <= 1'b0;
      dyn_en_q <= 1'b0;
    end else if (link.cmd == dowl_pkg::CMD_MRS) begin
      cwl_q <= link.cwl;
      al_q <= link.al;
      cl_q <= link.cl;
      dll_off_q <= link.dll_off;
      dyn_en_q <= link.dyn_en;
    end
  end

  // leveling mode flag
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wl_mode_q <= 1'b0;
    end else if (link.cmd == dowl_pkg::CMD_WL_ENTER) begin
      wl_mode_q <= 1'b1;
    end else if (link.cmd == dowl_pkg::CMD_WL_EXIT) begin
      wl_mode_q <= 1'b0;
    end
  end

  // latency arithmetic; settings too small to subtract from clamp at zero
  always_comb begin
    wl_sum = {1'b0, cwl_q} + {1'b0, al_q};
    rl_sum = {1'b0, cl_q} + {1'b0, al_q};
    if (wl_sum > (dowl_pkg::LAT_W + 1)'(dowl_pkg::NOM_TO_WR_SUB)) begin
      term_tap = TAP_W'(wl_sum - (dowl_pkg::LAT_W + 1)'(dowl_pkg::NOM_TO_WR_SUB));
    end else begin
      term_tap = '0;
    end
    if (!dll_off_q) begin
      rd_tap = TAP_W'(rl_sum);
    end else if (rl_sum > (dowl_pkg::LAT_W + 1)'(dowl_pkg::DLL_OFF_RD_SUB)) begin
      rd_tap = TAP_W'(rl_sum - (dowl_pkg::LAT_W + 1)'(dowl_pkg::DLL_OFF_RD_SUB));
    end else begin
      rd_tap = '0;
    end
  end

  // dynamic switch only when enabled and not leveling
  always_comb begin
    wr_in[1] = (link.cmd == dowl_pkg::CMD_WRITE) && dyn_en_q && !wl_mode_q;
    wr_in[0] = link.bc4;
    rd_in = (link.cmd == dowl_pkg::CMD_READ);
  end

  // the termination input and the write share one latency
  dowl_dly #(
    .W(1),
    .DEPTH(DEPTH)
  ) u_odt_dly (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_i(link.odt),
    .tap_i(term_tap),
    .out_o(odt_late)
  );

  dowl_dly #(
    .W(2),
    .DEPTH(DEPTH)
  ) u_wr_dly (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_i(wr_in),
    .tap_i(term_tap),
    .out_o(wr_late)
  );

  dowl_dly #(
    .W(1),
    .DEPTH(DEPTH)
  ) u_rd_dly (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_i(rd_in),
    .tap_i(rd_tap),
    .out_o(rd_late)
  );

  // write termination window: opens at the switch point, closes after
  // 6 CK (4 for a chopped burst) plus the turn-off latency; a new write restarts it
  always_comb begin
    if (wr_late[1]) begin
      win_d = 1'b1;
    end else if (win_q && (win_cnt_q == '0)) begin
      win_d = 1'b0;
    end else begin
      win_d = win_q;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      win_q <= 1'b0;
      win_cnt_q <= '0;
    end else begin
      win_q <= win_d;
      if (wr_late[1]) begin
        if (wr_late[0]) begin
          win_cnt_q <= (TAP_W + 1)'(dowl_pkg::WR_TO_NOM_CHOP_CK - 1) + {1'b0, term_tap};
        end else begin
          win_cnt_q <= (TAP_W + 1)'(dowl_pkg::WR_TO_NOM_FULL_CK - 1) + {1'b0, term_tap};
        end
      end else if (win_cnt_q != '0) begin
        win_cnt_q <= win_cnt_q - 1'b1;
      end
    end
  end

  // termination state; write termination overrides nominal while the input is high
  always_comb begin
    if (!odt_late) begin
      term_d = dowl_pkg::TERM_OFF;
    end else if (win_d) begin
      term_d = dowl_pkg::TERM_WR;
    end else begin
      term_d = dowl_pkg::TERM_NOM;
    end
  end

  // the code changes on the reference edge; the analog stage places the
  // actual change 0.3 to 0.7 CK after it, finer than this clock can resolve
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      term_q <= dowl_pkg::TERM_OFF;
    end else begin
      term_q <= term_d;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_ref_q <= 1'b0;
    end else begin
      rd_ref_q <= rd_late;
    end
  end

  // the strobe phase code places the strobe inside the CK period; the
  // upper half of the code lands while CK is high
  always_comb begin
    ck_level = link.dqs_phase[PH_W-1];
  end

  // one flop feeds every data line, so line-to-line skew is zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fb_q <= 1'b0;
    end else if (!wl_mode_q) begin
      fb_q <= 1'b0;
    end else if (link.dqs_rise) begin
      fb_q <= ck_level;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fb_oe_q <= 1'b0;
    end else begin
      fb_oe_q <= wl_mode_q;
    end
  end

  always_comb begin
    link.dq_fb = {DQ_W{fb_q}};
    link.dq_oe = fb_oe_q;
  end

  always_comb begin
    term_o = term_q;
    rd_ref_o = rd_ref_q;
    wl_mode_o = wl_mode_q;
    dll_off_o = dll_off_q;
  end
endmodule // dowl_dev

// File: dowl_host.sv
// Purpose: controller end: issues writes, reads, mode loads and write leveling
// Assumes: requests are single-cycle pulses taken only while busy_o is low
// Notes: leveling searches the strobe phase code upward from zero
`timescale 1ns/1ps
module dowl_host #(
  parameter int DQ_W = 8,
  parameter int PH_W = 4
) (
  input wire logic clk_i, // memory clock CK
  input wire logic sys_rst_i, // async reset, high
  dowl_link_if.host link, // link to the device
  input wire logic wr_req_i, // write request pulse
  input wire logic wr_bc4_i, // write is a chopped burst
  input wire logic rd_req_i, // read request pulse
  input wire logic lvl_req_i, // start write leveling
  input wire logic cfg_load_i, // load latency settings
  input wire logic [dowl_pkg::LAT_W-1:0] cfg_cwl_i, // write latency
  input wire logic [dowl_pkg::LAT_W-1:0] cfg_al_i, // additive latency
  input wire logic [dowl_pkg::LAT_W-1:0] cfg_cl_i, // read latency
  input wire logic cfg_dll_off_i, // DLL-disabled operation
  input wire logic cfg_dyn_en_i, // dynamic termination enable
  output logic busy_o, // requests ignored while high
  output logic lvl_done_o, // leveling locked, pulse
  output logic lvl_fail_o, // leveling found no edge, pulse
  output logic [PH_W-1:0] lvl_phase_o // locked strobe phase code
);
  typedef enum logic [1:0] {S_IDLE, S_ODT_HOLD, S_LVL_WAIT, S_LVL_FB} dowl_hstate_type;

  dowl_hstate_type state_q;
  logic [7:0] cnt_q;
  logic [7:0] relock_q;
  logic [PH_W-1:0] phase_q;
  logic prev_fb_q;
  logic fb_now;
  logic busy_q;
  logic done_q;
  logic fail_q;

  // feedback only counts while the device is actually driving the data lines
  assign fb_now = link.dq_oe && (&link.dq_fb);

  // latency change: the device DLL must relock before synchronous commands
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      relock_q <= '0;
    end else if (state_q == S_IDLE && !busy_q && cfg_load_i) begin
      relock_q <= 8'(dowl_pkg::RELOCK_CK);
    end else if (relock_q != '0) begin
      relock_q <= relock_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      phase_q <= '0;
      prev_fb_q <= 1'b1;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      link.cmd <= dowl_pkg::CMD_NOP;
      link.bc4 <= 1'b0;
      link.odt <= 1'b0;
      link.dqs_rise <= 1'b0;
      link.dqs_phase <= '0;
      link.cwl <= dowl_pkg::CWL_RST;
      link.al <= dowl_pkg::AL_RST;
      link.cl <= dowl_pkg::CL_RST;
      link.dll_off <= 1'b0;
      link.dyn_en <= 1'b0;
    end else begin
      link.cmd <= dowl_pkg::CMD_NOP;
      link.dqs_rise <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (!busy_q && cfg_load_i) begin
            link.cmd <= dowl_pkg::CMD_MRS;
            link.cwl <= cfg_cwl_i;
            link.al <= cfg_al_i;
            link.cl <= cfg_cl_i;
            link.dll_off <= cfg_dll_off_i;
            link.dyn_en <= cfg_dyn_en_i;
          end else if (!busy_q && wr_req_i) begin
            link.cmd <= dowl_pkg::CMD_WRITE;
            link.bc4 <= wr_bc4_i;
            link.odt <= 1'b1;
            cnt_q <= wr_bc4_i ? 8'(dowl_pkg::TERM_HOLD_CHOP_CK - 1) :
                                8'(dowl_pkg::TERM_HOLD_FULL_CK - 1);
            state_q <= S_ODT_HOLD;
          end else if (!busy_q && rd_req_i) begin
            link.cmd <= dowl_pkg::CMD_READ;
          end else if (!busy_q && lvl_req_i) begin
            link.cmd <= dowl_pkg::CMD_WL_ENTER;
            cnt_q <= 8'(dowl_pkg::LVL_FIRST_WAIT_CK);
            phase_q <= '0;
            prev_fb_q <= 1'b1;
            state_q <= S_LVL_WAIT;
          end
        end
        S_ODT_HOLD: begin
          if (cnt_q == '0) begin
            link.odt <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_LVL_WAIT: begin
          if (cnt_q == '0) begin
            link.dqs_rise <= 1'b1;
            link.dqs_phase <= phase_q;
            cnt_q <= 8'(dowl_pkg::LVL_FB_WAIT_CK);
            state_q <= S_LVL_FB;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_LVL_FB: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (fb_now && !prev_fb_q) begin
            link.cmd <= dowl_pkg::CMD_WL_EXIT;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end else if (phase_q == '1) begin
            link.cmd <= dowl_pkg::CMD_WL_EXIT;
            fail_q <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            prev_fb_q <= fb_now;
            phase_q <= phase_q + 1'b1;
            link.dqs_rise <= 1'b1;
            link.dqs_phase <= phase_q + 1'b1;
            cnt_q <= 8'(dowl_pkg::LVL_FB_WAIT_CK);
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // busy covers the cycle a mode load, write or leveling command leaves, so requests never collide
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b1;
    end else begin
      busy_q <= (state_q != S_IDLE) || (relock_q > 8'h01) ||
                (state_q == S_IDLE && !busy_q && (cfg_load_i || wr_req_i || lvl_req_i));
    end
  end

  assign busy_o = busy_q;
  assign lvl_done_o = done_q;
  assign lvl_fail_o = fail_q;
  assign lvl_phase_o = phase_q;
endmodule // dowl_host

// File: dowl_chk.sv
// Purpose: link checker for termination hold, relock spacing and leveling
// Assumes: one clock, asynchronous high reset
// Notes: long waits are counted in helper counters, not repetitions
`timescale 1ns/1ps
module dowl_chk #(
  parameter int DQ_W = 8,
  parameter int PH_W = 4
) (
  input wire logic clk_i, // memory clock
  input wire logic sys_rst_i, // async reset, high
  input wire dowl_pkg::dowl_cmd_type cmd, // command
  input wire logic bc4, // chopped burst
  input wire logic odt, // termination input
  input wire logic dqs_rise, // strobe edge
  input wire logic [PH_W-1:0] dqs_phase, // strobe phase
  input wire logic [DQ_W-1:0] dq_fb, // feedback
  input wire logic dq_oe // device drives dq
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [5:0] wl_cnt_q;
  logic [5:0] mrs_cnt_q;
  // saturating ages of the last leveling entry and mode load
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) wl_cnt_q <= 6'h3F;
    else if (cmd == dowl_pkg::CMD_WL_ENTER) wl_cnt_q <= 6'h00;
    else if (wl_cnt_q != 6'h3F) wl_cnt_q <= wl_cnt_q + 6'h01;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) mrs_cnt_q <= 6'h3F;
    else if (cmd == dowl_pkg::CMD_MRS) mrs_cnt_q <= 6'h00;
    else if (mrs_cnt_q != 6'h3F) mrs_cnt_q <= mrs_cnt_q + 6'h01;
  end
  sequence s_odt_full;
    odt [*6] ##1 !odt;
  endsequence
  sequence s_odt_chop;
    odt [*4] ##1 !odt;
  endsequence
  property p_odt_full;
    cmd == dowl_pkg::CMD_WRITE && !bc4 |-> s_odt_full;
  endproperty
  a_odt_full: assert property (p_odt_full) else $error("odt short on full burst");
  property p_odt_chop;
    cmd == dowl_pkg::CMD_WRITE && bc4 |-> s_odt_chop;
  endproperty
  a_odt_chop: assert property (p_odt_chop) else $error("odt wrong on chopped burst");
  property p_first_dqs;
    dqs_rise |-> int'(wl_cnt_q) >= dowl_pkg::LVL_FIRST_WAIT_CK - 1;
  endproperty
  a_first_dqs: assert property (p_first_dqs) else $error("strobe too soon after entry");
  property p_fb_val;
    dqs_rise |=> dq_fb == {DQ_W{$past(dqs_phase[PH_W-1])}};
  endproperty
  a_fb_val: assert property (p_fb_val) else $error("feedback late or wrong");
  property p_fb_skew;
    dq_oe |-> (dq_fb == '0 || dq_fb == '1);
  endproperty
  a_fb_skew: assert property (p_fb_skew) else $error("feedback lines differ");
  property p_fb_idle;
    !dq_oe |-> dq_fb == '0;
  endproperty
  a_fb_idle: assert property (p_fb_idle) else $error("feedback outside leveling");
  property p_oe_on;
    cmd == dowl_pkg::CMD_WL_ENTER |-> ##[1:2] dq_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("dq not driven in leveling");
  property p_relock;
    cmd == dowl_pkg::CMD_READ |-> int'(mrs_cnt_q) >= dowl_pkg::RELOCK_CK - 1;
  endproperty
  a_relock: assert property (p_relock) else $error("read inside relock delay");
  property p_dqs_gap;
    dqs_rise |=> !dqs_rise [*2];
  endproperty
  a_dqs_gap: assert property (p_dqs_gap) else $error("strobes too close");
endmodule // dowl_chk

// File: tb_top.sv
// Purpose: both ends joined, model of termination, read reference, leveling
// Assumes: inputs change 1 ns after the rising edge
// Notes: latencies drawn at random per configuration
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr_req_i = 1'b0, wr_bc4_i = 1'b0, rd_req_i = 1'b0, lvl_req_i = 1'b0, cfg_load_i = 1'b0;
  logic [4:0] cwl_i = 5'h05, al_i = 5'h00, cl_i = 5'h06;
  logic dll_i = 1'b0, dyn_i = 1'b0;
  logic busy_o, lvl_done_o, lvl_fail_o, rd_ref_o, wl_mode_o, dll_off_o;
  logic [3:0] lvl_phase_o;
  dowl_pkg::dowl_term_type term_o;
  int err_count = 0, checks = 0, cyc = 0, rd_seen = 0;
  int rd_due[$];
  always #5 clk_i = ~clk_i;
  dowl_link_if i_dowl_link_if ();
  dowl_host i_dowl_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(i_dowl_link_if),
    .wr_req_i(wr_req_i), .wr_bc4_i(wr_bc4_i), .rd_req_i(rd_req_i), .lvl_req_i(lvl_req_i),
    .cfg_load_i(cfg_load_i), .cfg_cwl_i(cwl_i), .cfg_al_i(al_i), .cfg_cl_i(cl_i),
    .cfg_dll_off_i(dll_i), .cfg_dyn_en_i(dyn_i), .busy_o(busy_o), .lvl_done_o(lvl_done_o),
    .lvl_fail_o(lvl_fail_o), .lvl_phase_o(lvl_phase_o));
  dowl_dev i_dowl_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(i_dowl_link_if), .term_o(term_o),
    .rd_ref_o(rd_ref_o), .wl_mode_o(wl_mode_o), .dll_off_o(dll_off_o));
  dowl_chk i_dowl_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd(i_dowl_link_if.cmd),
    .bc4(i_dowl_link_if.bc4), .odt(i_dowl_link_if.odt), .dqs_rise(i_dowl_link_if.dqs_rise),
    .dqs_phase(i_dowl_link_if.dqs_phase), .dq_fb(i_dowl_link_if.dq_fb), .dq_oe(i_dowl_link_if.dq_oe));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk_i);
    #1;
    s = 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("busy", 8'h00, {7'h0, busy_o});
  endtask
  always @(posedge clk_i) begin
    cyc++;
    // model: read reference due CL plus AL, less one with the DLL off, edges after the read
    if (i_dowl_link_if.cmd == dowl_pkg::CMD_READ) begin
      rd_seen++;
      rd_due.push_back(cyc + int'(cl_i) + int'(al_i) - int'(dll_i));
    end
    // whole run needs about 350 cycles
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  // compare the model at mid-cycle, when the reference pulse has settled
  always @(negedge clk_i) begin
    if (!sys_rst_i) begin
      chk("rd_model", {7'h0, rd_due.size() > 0 && rd_due[0] == cyc}, {7'h0, rd_ref_o});
      if (rd_due.size() > 0 && rd_due[0] == cyc) void'(rd_due.pop_front());
    end
  end
  initial begin
    int L, len, lat, n, seen;
    logic [7:0] exp;
    void'($urandom(32'h3204));
    repeat (8) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    chk("term_rst", 8'(dowl_pkg::TERM_OFF), 8'(term_o));
    @(posedge clk_i);
    #1;
    for (int i = 0; i < 4; i++) begin
      cwl_i = 5'(5 + $urandom_range(5));
      al_i = 5'($urandom_range(2));
      cl_i = 5'(5 + $urandom_range(6));
      dll_i = i[0];
      dyn_i = i[1];
      seen = rd_seen;
      pulse(cfg_load_i);
      pulse(rd_req_i);
      wait_idle();
      chk("refused", 8'h00, 8'(rd_seen - seen));
      chk("dll_off", {7'h0, dll_i}, {7'h0, dll_off_o});
      for (int b = 0; b < 2; b++) begin
        wr_bc4_i = b[0];
        len = b ? 4 : 6;
        L = int'(cwl_i) + int'(al_i) - 2;
        pulse(wr_req_i);
        chk("cmd", 8'(dowl_pkg::CMD_WRITE), 8'(i_dowl_link_if.cmd));
        for (int j = 0; j < 2 * L + len + 2; j++) begin
          @(posedge clk_i);
          #1;
          exp = (j >= L && j < len + L) ? 8'(dyn_i ? dowl_pkg::TERM_WR : dowl_pkg::TERM_NOM) : 8'h00;
          chk("term", exp, 8'(term_o));
          // write window closes 6 CK (4 when chopped) plus turn-off latency after the switch
          chk("wr_win", {7'h0, dyn_i && j >= L && j < 2 * L + len}, {7'h0, i_dowl_dev.win_q});
        end
        wait_idle();
      end
      lat = int'(cl_i) + int'(al_i) - int'(dll_i);
      pulse(rd_req_i);
      for (int j = 0; j < lat + 3; j++) begin
        @(posedge clk_i);
        #1;
        chk("rd_ref", {7'h0, j == lat}, {7'h0, rd_ref_o});
      end
      wait_idle();
    end
    pulse(lvl_req_i);
    repeat (3) @(posedge clk_i);
    #1;
    chk("wl_mode", 8'h01, {7'h0, wl_mode_o});
    n = 0;
    while (lvl_done_o !== 1'b1 && lvl_fail_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("lvl_done", 8'h01, {7'h0, lvl_done_o});
    chk("lvl_fail", 8'h00, {7'h0, lvl_fail_o});
    // feedback first rises once the phase msb is set
    chk("lvl_phase", 8'h08, {4'h0, lvl_phase_o});
    repeat (3) @(posedge clk_i);
    #1;
    chk("wl_exit", 8'h00, {7'h0, wl_mode_o});
    final_report();
  end
endmodule // tb_top
